// *** ua8_top.sv ***
// ua8_top: 8-bit asynchronous receiver and transmitter with register port
// assumes clk_src_i carries tick pulses at 8x baud made on clk_i,
// and rx_src_i are line pins from outside the clock domain
`timescale 1ns/1ps

module ua8_top (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [15:0] clk_src_i,
    input  wire logic [15:0] rx_src_i,
    output logic      [3:0]  tx_o
);

    // register port decode
    wire logic        wr_rx_csr  = wr_i && (addr_i == ua8_pkg::ADDR_RX_CSR);
    wire logic        wr_rx_in   = wr_i && (addr_i == ua8_pkg::ADDR_RX_INPUT);
    wire logic        wr_rx_out  = wr_i && (addr_i == ua8_pkg::ADDR_RX_OUTPUT);
    wire logic        wr_tx_buf  = wr_i && (addr_i == ua8_pkg::ADDR_TX_BUFFER);
    wire logic        wr_tx_csr  = wr_i && (addr_i == ua8_pkg::ADDR_TX_CSR);
    wire logic        wr_tx_in   = wr_i && (addr_i == ua8_pkg::ADDR_TX_INPUT);
    wire logic        wr_tx_out  = wr_i && (addr_i == ua8_pkg::ADDR_TX_OUTPUT);
    wire logic        rd_rx_csr  = rd_i && (addr_i == ua8_pkg::ADDR_RX_CSR);
    wire logic        rd_tx_csr  = rd_i && (addr_i == ua8_pkg::ADDR_TX_CSR);

    // configuration registers
    logic [7:0]            rx_in_q;
    logic [7:0]            rx_out_q;
    logic [3:0]            tx_in_q;
    logic [2:0]            tx_out_q;
    logic [2:0]            rx_ctrl_q;
    logic [2:0]            tx_ctrl_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_in_q   <= ua8_pkg::RST_BYTE;
            rx_out_q  <= ua8_pkg::RST_BYTE;
            tx_in_q   <= ua8_pkg::RST_BYTE[3:0];
            tx_out_q  <= ua8_pkg::RST_BYTE[2:0];
            rx_ctrl_q <= ua8_pkg::RST_BYTE[2:0];
            tx_ctrl_q <= ua8_pkg::RST_BYTE[2:0];
        end else begin
            if (wr_rx_in)  rx_in_q   <= wdata_i;
            if (wr_rx_out) rx_out_q  <= wdata_i;
            if (wr_tx_in)  tx_in_q   <= wdata_i[ua8_pkg::CLK_SEL_MSB:ua8_pkg::CLK_SEL_LSB];
            if (wr_tx_out) tx_out_q  <= wdata_i[ua8_pkg::TX_OUT_EN_BIT:0];
            if (wr_rx_csr) rx_ctrl_q <= wdata_i[ua8_pkg::CTRL_MSB:0];
            if (wr_tx_csr) tx_ctrl_q <= wdata_i[ua8_pkg::CTRL_MSB:0];
        end
    end

    wire logic rx_en      = rx_ctrl_q[0];
    wire logic rx_par_en  = rx_ctrl_q[1];
    wire logic rx_par_odd = rx_ctrl_q[2];
    wire logic tx_en      = tx_ctrl_q[0];
    wire logic tx_par_en  = tx_ctrl_q[1];
    wire logic tx_par_odd = tx_ctrl_q[2];

    // line inputs pass two flops before use
    logic [15:0] rx_sync1_q;
    logic [15:0] rx_sync2_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_sync1_q <= {2{ua8_pkg::RST_IDLE_BYTE}};
            rx_sync2_q <= {2{ua8_pkg::RST_IDLE_BYTE}};
        end else begin
            rx_sync1_q <= rx_src_i;
            rx_sync2_q <= rx_sync1_q;
        end
    end

    // source and clock selection
    wire logic rx_line = rx_sync2_q[rx_in_q[ua8_pkg::SRC_SEL_MSB:ua8_pkg::SRC_SEL_LSB]];
    wire logic rx_tick = clk_src_i[rx_in_q[ua8_pkg::CLK_SEL_MSB:ua8_pkg::CLK_SEL_LSB]];
    wire logic tx_tick = clk_src_i[tx_in_q];

    // ---------------- receiver ----------------
    ua8_pkg::ua8_state_t rx_state_q;
    ua8_pkg::ua8_state_t rx_state_d;
    logic [2:0]          rx_ovs_q;
    logic [2:0]          rx_ovs_d;
    logic [2:0]          rx_bit_q;
    logic [2:0]          rx_bit_d;
    logic [7:0]          rx_shift_q;
    logic [7:0]          rx_shift_d;
    logic [7:0]          rx_buf_q;
    logic                rx_par_bad_q;
    logic                rx_par_bad_d;
    logic                rx_done;
    logic                rx_stop_bad;

    wire logic rx_sample = rx_tick && (rx_ovs_q == ua8_pkg::OVS_LAST);

    always_comb begin
        rx_state_d   = rx_state_q;
        rx_ovs_d     = rx_ovs_q;
        rx_bit_d     = rx_bit_q;
        rx_shift_d   = rx_shift_q;
        rx_par_bad_d = rx_par_bad_q;
        rx_done      = 1'b0;
        rx_stop_bad  = 1'b0;
        if (rx_tick) begin
            rx_ovs_d = rx_ovs_q + 3'h1;
        end
        unique case (rx_state_q)
            ua8_pkg::ST_IDLE: begin
                rx_ovs_d = ua8_pkg::CNT_ZERO;
                if (rx_en && !rx_line) begin
                    rx_state_d = ua8_pkg::ST_START;
                end
            end
            ua8_pkg::ST_START: begin
                if (rx_tick && (rx_ovs_q == ua8_pkg::OVS_MID)) begin
                    rx_ovs_d = ua8_pkg::CNT_ZERO;
                    rx_bit_d = ua8_pkg::CNT_ZERO;
                    rx_par_bad_d = 1'b0;
                    rx_state_d = rx_line ? ua8_pkg::ST_IDLE : ua8_pkg::ST_DATA;
                end
            end
            ua8_pkg::ST_DATA: begin
                if (rx_sample) begin
                    rx_shift_d = {rx_line, rx_shift_q[7:1]};
                    rx_bit_d   = rx_bit_q + 3'h1;
                    if (rx_bit_q == ua8_pkg::DATA_LAST) begin
                        rx_state_d = rx_par_en ? ua8_pkg::ST_PAR : ua8_pkg::ST_STOP;
                    end
                end
            end
            ua8_pkg::ST_PAR: begin
                if (rx_sample) begin
                    rx_par_bad_d = rx_line != ua8_pkg::ua8_parity(rx_shift_q, rx_par_odd);
                    rx_state_d   = ua8_pkg::ST_STOP;
                end
            end
            ua8_pkg::ST_STOP: begin
                if (rx_sample) begin
                    rx_done     = 1'b1;
                    rx_stop_bad = !rx_line;
                    rx_state_d  = ua8_pkg::ST_IDLE;
                end
            end
            default: begin
                rx_state_d = ua8_pkg::ST_IDLE;
            end
        endcase
        if (!rx_en) begin
            rx_state_d = ua8_pkg::ST_IDLE;
            rx_done    = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_state_q   <= ua8_pkg::ST_IDLE;
            rx_ovs_q     <= ua8_pkg::CNT_ZERO;
            rx_bit_q     <= ua8_pkg::CNT_ZERO;
            rx_shift_q   <= ua8_pkg::RST_BYTE;
            rx_par_bad_q <= 1'b0;
        end else begin
            rx_state_q   <= rx_state_d;
            rx_ovs_q     <= rx_ovs_d;
            rx_bit_q     <= rx_bit_d;
            rx_shift_q   <= rx_shift_d;
            rx_par_bad_q <= rx_par_bad_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_buf_q <= ua8_pkg::RST_BYTE;
        end else if (rx_done) begin
            rx_buf_q <= rx_shift_q;
        end
    end

    // receive flags: a set in the same cycle as a status read wins
    logic rx_full_q;
    logic rx_ovr_q;
    logic rx_ferr_q;
    logic rx_perr_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_full_q <= 1'b0;
            rx_ovr_q  <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_perr_q <= 1'b0;
        end else begin
            rx_full_q <= rx_done || (rx_full_q && !rd_rx_csr);
            rx_ovr_q  <= (rx_done && rx_full_q) || (rx_ovr_q && !rd_rx_csr);
            rx_ferr_q <= (rx_done && rx_stop_bad) || (rx_ferr_q && !rd_rx_csr);
            rx_perr_q <= (rx_done && rx_par_bad_q && rx_par_en)
                         || (rx_perr_q && !rd_rx_csr);
        end
    end

    ua8_pkg::ua8_rx_csr_t rx_csr;
    assign rx_csr.parity_err  = rx_perr_q;
    assign rx_csr.overrun_err = rx_ovr_q;
    assign rx_csr.framing_err = rx_ferr_q;
    assign rx_csr.active      = rx_state_q != ua8_pkg::ST_IDLE;
    assign rx_csr.reg_full    = rx_full_q;
    assign rx_csr.parity_odd  = rx_par_odd;
    assign rx_csr.parity_en   = rx_par_en;
    assign rx_csr.enable      = rx_en;

    // ---------------- transmitter ----------------
    ua8_pkg::ua8_state_t tx_state_q;
    ua8_pkg::ua8_state_t tx_state_d;
    logic [2:0]          tx_ovs_q;
    logic [2:0]          tx_ovs_d;
    logic [2:0]          tx_bit_q;
    logic [2:0]          tx_bit_d;
    logic [7:0]          tx_shift_q;
    logic [7:0]          tx_shift_d;
    logic [7:0]          tx_buf_q;
    logic                tx_par_q;
    logic                tx_par_d;
    logic                tx_empty_q;
    logic                tx_load;
    logic                tx_finish;
    logic                tx_line_d;

    wire logic tx_bit_end = tx_tick && (tx_ovs_q == ua8_pkg::OVS_LAST);

    always_comb begin
        tx_state_d = tx_state_q;
        tx_ovs_d   = tx_ovs_q;
        tx_bit_d   = tx_bit_q;
        tx_shift_d = tx_shift_q;
        tx_par_d   = tx_par_q;
        tx_load    = 1'b0;
        tx_finish  = 1'b0;
        tx_line_d  = 1'b1;
        if (tx_tick) begin
            tx_ovs_d = tx_ovs_q + 3'h1;
        end
        unique case (tx_state_q)
            ua8_pkg::ST_IDLE: begin
                tx_ovs_d = ua8_pkg::CNT_ZERO;
                if (tx_en && !tx_empty_q) begin
                    tx_load    = 1'b1;
                    tx_shift_d = tx_buf_q;
                    tx_par_d   = ua8_pkg::ua8_parity(tx_buf_q, tx_par_odd);
                    tx_bit_d   = ua8_pkg::CNT_ZERO;
                    tx_state_d = ua8_pkg::ST_START;
                end
            end
            ua8_pkg::ST_START: begin
                tx_line_d = 1'b0;
                if (tx_bit_end) begin
                    tx_state_d = ua8_pkg::ST_DATA;
                end
            end
            ua8_pkg::ST_DATA: begin
                tx_line_d = tx_shift_q[0];
                if (tx_bit_end) begin
                    tx_shift_d = {1'b0, tx_shift_q[7:1]};
                    tx_bit_d   = tx_bit_q + 3'h1;
                    if (tx_bit_q == ua8_pkg::DATA_LAST) begin
                        tx_state_d = tx_par_en ? ua8_pkg::ST_PAR : ua8_pkg::ST_STOP;
                    end
                end
            end
            ua8_pkg::ST_PAR: begin
                tx_line_d = tx_par_q;
                if (tx_bit_end) begin
                    tx_state_d = ua8_pkg::ST_STOP;
                end
            end
            ua8_pkg::ST_STOP: begin
                if (tx_bit_end) begin
                    tx_finish  = 1'b1;
                    tx_state_d = ua8_pkg::ST_IDLE;
                end
            end
            default: begin
                tx_state_d = ua8_pkg::ST_IDLE;
            end
        endcase
        if (!tx_en) begin
            tx_state_d = ua8_pkg::ST_IDLE;
            tx_load    = 1'b0;
            tx_finish  = 1'b0;
            tx_line_d  = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_state_q <= ua8_pkg::ST_IDLE;
            tx_ovs_q   <= ua8_pkg::CNT_ZERO;
            tx_bit_q   <= ua8_pkg::CNT_ZERO;
            tx_shift_q <= ua8_pkg::RST_BYTE;
            tx_par_q   <= 1'b0;
        end else begin
            tx_state_q <= tx_state_d;
            tx_ovs_q   <= tx_ovs_d;
            tx_bit_q   <= tx_bit_d;
            tx_shift_q <= tx_shift_d;
            tx_par_q   <= tx_par_d;
        end
    end

    // buffer and its flags; a write beats the load that empties it
    logic tx_cmpl_q;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_buf_q   <= ua8_pkg::RST_BYTE;
            tx_empty_q <= 1'b1;
            tx_cmpl_q  <= 1'b0;
        end else begin
            if (wr_tx_buf) tx_buf_q <= wdata_i;
            tx_empty_q <= !wr_tx_buf && (tx_empty_q || tx_load);
            tx_cmpl_q  <= tx_finish || (tx_cmpl_q && !rd_tx_csr);
        end
    end

    ua8_pkg::ua8_tx_csr_t tx_csr;
    assign tx_csr.rsvd_hi    = 2'h0;
    assign tx_csr.complete   = tx_cmpl_q;
    assign tx_csr.reg_empty  = tx_empty_q;
    assign tx_csr.rsvd_lo    = 1'b0;
    assign tx_csr.parity_odd = tx_par_odd;
    assign tx_csr.parity_en  = tx_par_en;
    assign tx_csr.enable     = tx_en;

    // output routing, registered per pin; unrouted pins idle high
    wire logic [1:0] tx_route = tx_out_q[ua8_pkg::TX_OUT_SEL_MSB:0];
    wire logic       tx_oen   = tx_out_q[ua8_pkg::TX_OUT_EN_BIT];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_o <= ua8_pkg::RST_IDLE_BYTE[3:0];
        end else begin
            for (int i = 0; i < 4; i++) begin
                tx_o[i] <= (tx_oen && (tx_route == 2'(i))) ? tx_line_d : 1'b1;
            end
        end
    end

    // read data, one cycle after the strobe
    logic [7:0] rd_mux;

    always_comb begin
        unique case (addr_i)
            ua8_pkg::ADDR_RX_SHIFT:  rd_mux = rx_shift_q;
            ua8_pkg::ADDR_RX_BUFFER: rd_mux = rx_buf_q;
            ua8_pkg::ADDR_RX_CSR:    rd_mux = rx_csr;
            ua8_pkg::ADDR_RX_FUNC:   rd_mux = ua8_pkg::RX_FUNC_CODE;
            ua8_pkg::ADDR_RX_INPUT:  rd_mux = rx_in_q;
            ua8_pkg::ADDR_RX_OUTPUT: rd_mux = rx_out_q;
            ua8_pkg::ADDR_TX_SHIFT:  rd_mux = tx_shift_q;
            ua8_pkg::ADDR_TX_BUFFER: rd_mux = tx_buf_q;
            ua8_pkg::ADDR_TX_CSR:    rd_mux = tx_csr;
            ua8_pkg::ADDR_TX_FUNC:   rd_mux = ua8_pkg::TX_FUNC_CODE;
            ua8_pkg::ADDR_TX_INPUT:  rd_mux = {4'h0, tx_in_q};
            ua8_pkg::ADDR_TX_OUTPUT: rd_mux = {5'h00, tx_out_q};
            default:                 rd_mux = ua8_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= ua8_pkg::RST_BYTE;
        end else if (rd_i) begin
            rdata_o <= rd_mux;
        end else begin
            rdata_o <= ua8_pkg::RST_BYTE;
        end
    end

endmodule : ua8_top

// *** ua8_pkg.sv ***
// ua8_pkg: register map, field layout, codes and helpers for the 8-bit serial pair
// assumes a single clock domain and a plain address/strobe register port
package ua8_pkg;

    // register addresses, receiver group
    localparam logic [3:0] ADDR_RX_SHIFT   = 4'h0;
    localparam logic [3:0] ADDR_RX_UNUSED  = 4'h1;
    localparam logic [3:0] ADDR_RX_BUFFER  = 4'h2;
    localparam logic [3:0] ADDR_RX_CSR     = 4'h3;
    localparam logic [3:0] ADDR_RX_FUNC    = 4'h4;
    localparam logic [3:0] ADDR_RX_INPUT   = 4'h5;
    localparam logic [3:0] ADDR_RX_OUTPUT  = 4'h6;
    // register addresses, transmitter group
    localparam logic [3:0] ADDR_TX_SHIFT   = 4'h8;
    localparam logic [3:0] ADDR_TX_BUFFER  = 4'h9;
    localparam logic [3:0] ADDR_TX_UNUSED  = 4'hA;
    localparam logic [3:0] ADDR_TX_CSR     = 4'hB;
    localparam logic [3:0] ADDR_TX_FUNC    = 4'hC;
    localparam logic [3:0] ADDR_TX_INPUT   = 4'hD;
    localparam logic [3:0] ADDR_TX_OUTPUT  = 4'hE;

    // fixed personality codes
    localparam logic [7:0] RX_FUNC_CODE    = 8'h05;
    localparam logic [7:0] TX_FUNC_CODE    = 8'h0D;

    // reset values
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] RST_IDLE_BYTE   = 8'hFF;

    // field positions
    localparam int unsigned SRC_SEL_MSB    = 7;
    localparam int unsigned SRC_SEL_LSB    = 4;
    localparam int unsigned CLK_SEL_MSB    = 3;
    localparam int unsigned CLK_SEL_LSB    = 0;
    localparam int unsigned CTRL_MSB       = 2;
    localparam int unsigned TX_OUT_EN_BIT  = 2;
    localparam int unsigned TX_OUT_SEL_MSB = 1;

    // eight oversampling ticks per bit; mid-bit after four
    localparam int unsigned OVS_RATE       = 8;
    localparam logic [2:0]  OVS_LAST       = 3'(OVS_RATE - 1);
    localparam logic [2:0]  OVS_MID        = 3'((OVS_RATE / 2) - 1);
    localparam logic [2:0]  DATA_LAST      = 3'h7;
    localparam logic [2:0]  CNT_ZERO       = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_PAR   = 3'b011,
        ST_STOP  = 3'b100
    } ua8_state_t;

    typedef struct packed {
        logic parity_err;
        logic overrun_err;
        logic framing_err;
        logic active;
        logic reg_full;
        logic parity_odd;
        logic parity_en;
        logic enable;
    } ua8_rx_csr_t;

    typedef struct packed {
        logic [1:0] rsvd_hi;
        logic       complete;
        logic       reg_empty;
        logic       rsvd_lo;
        logic       parity_odd;
        logic       parity_en;
        logic       enable;
    } ua8_tx_csr_t;

    // parity bit that makes the frame even (odd_sel=0) or odd (odd_sel=1)
    function automatic logic ua8_parity(input logic [7:0] data, input logic odd_sel);
        return (^data) ^ odd_sel;
    endfunction : ua8_parity

endpackage : ua8_pkg

// *** ua8_top_chk_sva.sv ***
// ua8_top_chk: port-level assertions for the serial pair
// assumes it is bound to ua8_top and sees only its ports
`timescale 1ns/1ps
module ua8_top_chk (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  rdata_o,
    input wire logic [15:0] clk_src_i,
    input wire logic [15:0] rx_src_i,
    input wire logic [3:0]  tx_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // write, one quiet cycle, read back the same place
    property p_rw(logic [3:0] a, logic [7:0] m);
        wr_i && addr_i == a ##1 !wr_i ##1 rd_i && addr_i == a
            |=> rdata_o == ($past(wdata_i, 3) & m);
    endproperty
    property p_const(logic [3:0] a, logic [7:0] v);
        rd_i && addr_i == a |=> rdata_o == v;
    endproperty

    chk_rx_func_code: assert property (p_const(ua8_pkg::ADDR_RX_FUNC, 8'h05))
        else $error("rx function register reads wrong code");
    chk_tx_func_code: assert property (p_const(ua8_pkg::ADDR_TX_FUNC, 8'h0D))
        else $error("tx function register reads wrong code");
    chk_rx_input_rw: assert property (p_rw(ua8_pkg::ADDR_RX_INPUT, 8'hFF))
        else $error("rx input select does not hold written value");
    chk_tx_input_rw: assert property (p_rw(ua8_pkg::ADDR_TX_INPUT, 8'h0F))
        else $error("tx input select does not hold written value");
    chk_tx_output_rw: assert property (p_rw(ua8_pkg::ADDR_TX_OUTPUT, 8'h07))
        else $error("tx output select does not hold written value");
    chk_tx_csr_rsvd: assert property (
        rd_i && addr_i == ua8_pkg::ADDR_TX_CSR |=> (rdata_o & 8'hC8) == 8'h00)
        else $error("tx status reserved bits not zero");
    chk_tx_one_pin: assert property ($countones(~tx_o) <= 1)
        else $error("more than one tx pin driven low");
    chk_tx_off_idle: assert property (
        wr_i && addr_i == ua8_pkg::ADDR_TX_CSR && !wdata_i[0] |-> ##[1:2] tx_o == 4'hF)
        else $error("tx line not idle after disable");

    cover property (rd_i && addr_i == ua8_pkg::ADDR_RX_CSR ##1 rdata_o[6]);
    cover property (rd_i && addr_i == ua8_pkg::ADDR_RX_CSR ##1 rdata_o[5]);
    cover property (rd_i && addr_i == ua8_pkg::ADDR_TX_CSR ##1 rdata_o[5]);
endmodule : ua8_top_chk

// *** ua8_remote.sv ***
// ua8_remote: far-end serial device, sends and captures frames by tick count
// assumes tick_i pulses eight times a bit; its line idles high
`timescale 1ns/1ps
module ua8_remote (
    input  wire logic clk_i,
    input  wire logic tick_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    task automatic wait_ticks(input int n);
        repeat (n) begin
            @(posedge clk_i);
            for (int k = 0; k < 16 && tick_i !== 1'b1; k++) @(posedge clk_i);
        end
    endtask : wait_ticks

    // a low stop is held six ticks so a false start rechecks high
    task automatic send(input logic [7:0] d, input logic pe, pb, sb);
        logic [10:0] f;
        f = pe ? {sb, pb, d, 1'b0} : {1'b1, sb, d, 1'b0};
        for (int i = 0; i < (pe ? 11 : 10); i++) begin
            line_o <= f[i];
            wait_ticks((i == (pe ? 10 : 9) && !sb) ? 6 : 8);
        end
        line_o <= 1'b1;
        wait_ticks(sb ? 1 : 6);
    endtask : send

    task automatic recv(input logic pe, output logic [9:0] f);
        f = 10'h3FF;
        for (int i = 0; i < 3000 && line_i !== 1'b0; i++) @(posedge clk_i);
        if (line_i === 1'b0) begin
            wait_ticks(4);
            for (int i = 0; i < (pe ? 10 : 9); i++) begin
                wait_ticks(8);
                f[i] = line_i;
            end
        end
    endtask : recv
endmodule : ua8_remote

// *** ua8_top_tb.sv ***
// ua8_top_tb: self-checking bench for the serial pair
// assumes ua8_remote on rx source 0 and tx pin 0, ticks on clock source 0
`timescale 1ns/1ps
module ua8_top_tb;
    logic        clk_i;
    logic        srst_i;
    logic [3:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic [15:0] clk_src_i;
    logic [15:0] rx_src_i;
    logic [3:0]  tx_o;
    logic        line;
    logic        act;
    int          tdiv;
    int          failures;
    int          comparisons;

    ua8_top dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
                 .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_src_i(clk_src_i),
                 .rx_src_i(rx_src_i), .tx_o(tx_o));
    ua8_remote rem (.clk_i(clk_i), .tick_i(clk_src_i[0]), .line_i(tx_o[0]), .line_o(line));
    assign rx_src_i = {15'h7FFF, line};

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // one tick every four cycles
    always @(posedge clk_i) begin
        tdiv      <= (tdiv + 1) % 4;
        clk_src_i <= {15'h0000, tdiv == 3};
    end

    task automatic stop_test();
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
        @(posedge clk_i);
    endtask : rd

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string n);
        logic [7:0] v;
        rd(a, v);
        chk(n, e, v);
    endtask : rd_chk

    task automatic rx_get(input logic [7:0] es, input logic [7:0] ed);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 400 && s[3] !== 1'b1; i++) begin
            rd(ua8_pkg::ADDR_RX_CSR, s);
            act |= s[4];
        end
        chk("rx status", es, s & 8'hEF);
        if (s[3] !== 1'b1) stop_test();
        rd_chk(ua8_pkg::ADDR_RX_BUFFER, ed, "rx buffer");
    endtask : rx_get

    task automatic rx_one(input logic [7:0] c, d, input logic pe, pb, sb, input logic [7:0] es);
        wr(ua8_pkg::ADDR_RX_CSR, c);
        fork
            rem.send(d, pe, pb, sb);
            rx_get(es, d);
        join
    endtask : rx_one

    task automatic tx_one(input logic [7:0] c, d);
        logic [9:0] f;
        logic [7:0] s;
        fork
            rem.recv(c[1], f);
            begin
                wr(ua8_pkg::ADDR_TX_CSR, c);
                wr(ua8_pkg::ADDR_TX_BUFFER, d);
            end
        join
        chk("tx data", d, f[7:0]);
        chk("tx tail", {6'h00, 1'b1, c[1] ? ^d ^ c[2] : 1'b1}, {6'h00, f[9:8]});
        if (f === 10'h3FF) stop_test();
        s = 8'h00;
        for (int i = 0; i < 50 && s[5] !== 1'b1; i++) rd(ua8_pkg::ADDR_TX_CSR, s);
        chk("tx status", 8'h30 | c, s);
        if (s[5] !== 1'b1) stop_test();
        rd_chk(ua8_pkg::ADDR_TX_CSR, 8'h10 | c, "tx status");
    endtask : tx_one

    task automatic t_regs();
        rd_chk(ua8_pkg::ADDR_RX_CSR, 8'h00, "rx status");
        rd_chk(ua8_pkg::ADDR_TX_CSR, 8'h10, "tx status");
        wr(ua8_pkg::ADDR_RX_FUNC, 8'hFF);
        rd_chk(ua8_pkg::ADDR_RX_FUNC, 8'h05, "rx function");
        rd_chk(ua8_pkg::ADDR_TX_FUNC, 8'h0D, "tx function");
        wr(ua8_pkg::ADDR_RX_INPUT, 8'hA3);
        rd_chk(ua8_pkg::ADDR_RX_INPUT, 8'hA3, "rx input");
        wr(ua8_pkg::ADDR_TX_INPUT, 8'hF6);
        rd_chk(ua8_pkg::ADDR_TX_INPUT, 8'h06, "tx input");
        wr(ua8_pkg::ADDR_TX_OUTPUT, 8'hFC);
        rd_chk(ua8_pkg::ADDR_TX_OUTPUT, 8'h04, "tx output");
        wr(4'h7, 8'h55);
        rd_chk(4'h7, 8'h00, "unmapped");
        wr(ua8_pkg::ADDR_RX_INPUT, 8'h00);
        wr(ua8_pkg::ADDR_TX_INPUT, 8'h00);
    endtask : t_regs

    task automatic t_rx();
        rx_one(8'h01, 8'hA5, 1'b0, 1'b0, 1'b1, 8'h09);
        chk("rx active", 8'h01, {7'h00, act});
        rx_one(8'h07, 8'h3C, 1'b1, ~^8'h3C, 1'b1, 8'h0F);
        rx_one(8'h03, 8'hC1, 1'b1, ^8'hC1, 1'b1, 8'h0B);
        rx_one(8'h07, 8'h5A, 1'b1, ^8'h5A, 1'b1, 8'h8F);
        rx_one(8'h05, 8'h81, 1'b0, 1'b0, 1'b1, 8'h0D);
        rx_one(8'h01, 8'h96, 1'b0, 1'b0, 1'b0, 8'h29);
        rx_one(8'h01, 8'h69, 1'b0, 1'b0, 1'b1, 8'h09);
    endtask : t_rx

    task automatic t_rx_overrun();
        rem.send(8'h11, 1'b0, 1'b0, 1'b1);
        rem.send(8'h22, 1'b0, 1'b0, 1'b1);
        rd_chk(ua8_pkg::ADDR_RX_CSR, 8'h49, "rx status");
        rd_chk(ua8_pkg::ADDR_RX_BUFFER, 8'h22, "rx buffer");
        rd_chk(ua8_pkg::ADDR_RX_CSR, 8'h01, "rx status");
        wr(ua8_pkg::ADDR_RX_CSR, 8'h00);
        rem.send(8'h77, 1'b0, 1'b0, 1'b1);
        rd_chk(ua8_pkg::ADDR_RX_CSR, 8'h00, "rx status");
    endtask : t_rx_overrun

    task automatic t_tx_b2b();
        logic [9:0] f;
        logic [9:0] g;
        fork
            begin
                rem.recv(1'b0, f);
                rem.recv(1'b0, g);
            end
            begin
                wr(ua8_pkg::ADDR_TX_CSR, 8'h01);
                wr(ua8_pkg::ADDR_TX_BUFFER, 8'h12);
                wr(ua8_pkg::ADDR_TX_BUFFER, 8'h34);
                rd_chk(ua8_pkg::ADDR_TX_CSR, 8'h01, "tx status");
            end
        join
        chk("tx first", 8'h12, f[7:0]);
        chk("tx second", 8'h34, g[7:0]);
    endtask : t_tx_b2b

    task automatic t_tx_off();
        logic [9:0] f;
        logic       hi;
        hi = 1'b1;
        wr(ua8_pkg::ADDR_TX_CSR, 8'h00);
        wr(ua8_pkg::ADDR_TX_BUFFER, 8'h5C);
        repeat (200) begin
            @(posedge clk_i);
            hi &= (tx_o === 4'hF);
        end
        chk("tx idle", 8'h01, {7'h00, hi});
        fork
            rem.recv(1'b0, f);
            wr(ua8_pkg::ADDR_TX_CSR, 8'h01);
        join
        chk("tx kept", 8'h5C, f[7:0]);
    endtask : t_tx_off

    initial begin
        srst_i      = 1'b1;
        addr_i      = 4'h0;
        wdata_i     = 8'h00;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        clk_src_i   = 16'h0000;
        tdiv        = 0;
        act         = 1'b0;
        failures    = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_rx();
        t_rx_overrun();
        tx_one(8'h01, 8'hA7);
        tx_one(8'h03, 8'h35);
        tx_one(8'h07, 8'h35);
        t_tx_b2b();
        t_tx_off();
        stop_test();
    end
endmodule : ua8_top_tb

bind ua8_top ua8_top_chk chk (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .clk_src_i(clk_src_i), .rx_src_i(rx_src_i), .tx_o(tx_o));
